// ### common/pwmtrq_pkg.sv
package pwmtrq_pkg;
	// ==============================================================
	// Geometry
	localparam int NCH = 4;
	localparam int CAP_W = 16;
	// ==============================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADR_MAIN_CTRL = 8'h00;
	localparam logic [7:0] ADR_CMD_SET = 8'h04;
	localparam logic [7:0] ADR_CHAN_ACT = 8'h0C;
	localparam logic [7:0] ADR_EVENT_CTRL = 8'h20;
	localparam logic [7:0] ADR_IRQ_EN_CLR = 8'h24;
	localparam logic [7:0] ADR_IRQ_EN_SET = 8'h28;
	localparam logic [7:0] ADR_IRQ_FLAG = 8'h2C;
	localparam logic [7:0] ADR_STATUS = 8'h30;
	localparam logic [7:0] ADR_CHAN_VAL0 = 8'h44;
	// ==============================================================
	// Main control fields
	localparam int MC_ONESHOT = 0;
	localparam int MC_WAVE = 1;
	localparam int MC_PRESC = 4;
	localparam int MC_CIRC = 8;
	localparam int MC_CAPEN = 12;
	localparam logic [1:0] WAVE_DUAL_RAMP = 2'h1;
	localparam logic [1:0] WAVE_DUAL_RAMP_ALT = 2'h2;
	localparam logic [1:0] WAVE_DUAL_SLOPE_BOTH = 2'h3;
	localparam logic [2:0] CMD_ONESHOT_DMA = 3'h6;
	// ==============================================================
	// Event control fields
	localparam int EC_ACT0 = 0;
	localparam int EC_ACT1 = 3;
	localparam int EC_WRAP_EO = 8;
	localparam int EC_RETRIG_EO = 9;
	localparam int EC_COUNT_EO = 10;
	localparam int EC_TCEI = 14;
	localparam int EC_MCEI = 16;
	localparam int EC_MCEO = 24;
	// ==============================================================
	// Interrupt flag positions
	localparam int IF_WRAP = 0;
	localparam int IF_RETRIG = 1;
	localparam int IF_COUNT = 2;
	localparam int IF_ERR = 3;
	localparam int IF_DFS = 11;
	localparam int IF_FAULT_A = 12;
	localparam int IF_FAULT_B = 13;
	localparam int IF_NONREC = 14;
	localparam int IF_MATCH = 16;
	localparam logic [31:0] IRQ_IMPL = 32'h000F_780F;
	// ==============================================================
	// Event actions and channel actions
	typedef enum logic [2:0] {
		EV0_OFF = 3'h0, EV0_RETRIG = 3'h1, EV0_COUNT = 3'h2, EV0_START = 3'h3,
		EV0_INC = 3'h4, EV0_ACTIVE = 3'h5, EV0_FAULT = 3'h6, EV0_RSVD = 3'h7
	} pwmtrq_ev0_e;
	typedef enum logic [2:0] {
		EV1_OFF = 3'h0, EV1_RETRIG = 3'h1, EV1_DIR = 3'h2, EV1_STOP = 3'h3,
		EV1_DEC = 3'h4, EV1_PPW = 3'h5, EV1_FAULT = 3'h6, EV1_RSVD = 3'h7
	} pwmtrq_ev1_e;
	localparam logic [1:0] CH_CAPTURE = 2'h0;
	localparam logic [1:0] CH_REC_FAULT = 2'h1;
	localparam logic [1:0] CH_NONREC_FAULT = 2'h2;
	// ==============================================================
	// Carriers
	typedef struct packed {
		logic wrap;
		logic retrig;
		logic count;
		logic cap_err;
		logic dbg_fault;
		logic [1:0] rec_fault;
		logic nonrec_fault;
		logic ramp_a_start;
		logic ramp_b_start;
		logic limit;
	} pwmtrq_cond_s;
	typedef struct packed {
		logic retrigger;
		logic step;
		logic increment;
		logic decrement;
		logic stop;
		logic dir_down;
		logic running;
		logic ppw_capture;
		logic nonrec_fault;
	} pwmtrq_ctr_cmd_s;
endpackage

// ### logic/pwmtrq_top.sv
`timescale 1ns/1ps
// Function
// R1 - One-shot DMA off: wrap DMA request on each overflow, underflow or retrigger.
// R2 - One-shot DMA on: trigger raised two cycles after the one-shot command write.
// R3 - Wrap DMA request cleared by DMA acknowledge in both one-shot settings.
// R4 - Compare channel DMA request set on match when one-shot off; ack clears.
// R5 - One-shot DMA on: no compare channel DMA requests.
// R6 - Capture channel request set on valid data, cleared on value read.
// R7 - Dual-ramp circular channel requests DMA at ramp B start.
// R8 - Dual-ramp circular: wrap request at ramp A start only after ack in B.
// R9 - Dual-slope circular channel requests DMA at down-count start.
// R10 - Dual-slope circular: wrap request at up-count start only after ack.
// R11 - One sticky interrupt flag per source, set when its condition occurs.
// R12 - Enable-set writes of one enable, enable-clear ones disable; zeros ignored.
// R13 - Interrupt asserted while flag and enable set, until cleared or disabled.
// R14 - All sources combined on one interrupt line; flags tell the cause.
// R15 - Wrap, retrigger, count and match events output only when enabled.
// R16 - Channel input event captures or raises recoverable or non-recoverable fault.
// R17 - Event one: retrigger, direction, stop, decrement, period capture or fault.
// R18 - Event zero: retrigger, count, start, increment, count-while-active or fault.
// R19 - Start action counts from rising edge until limit; later events ignored.
// R20 - Count-while-active steps every prescaled cycle while the event stays high.
// R21 - Channel and counter event-input enable bits gate their input actions.
// R22 - Every incoming event pulse gets the enabled action individually.
// R23 - Writing one clears an interrupt flag; a same-cycle condition wins.
module pwmtrq_top #(
	parameter int NCH = pwmtrq_pkg::NCH,
	parameter int CAP_W = pwmtrq_pkg::CAP_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Timer conditions and channels
	input wire pwmtrq_pkg::pwmtrq_cond_s cond_i,
	input wire logic [NCH-1:0] match_i,
	input wire logic [NCH-1:0] cap_valid_i,
	input wire logic [NCH*CAP_W-1:0] cap_data_i,
	// DMA
	output logic dma_wrap_req_o,
	output logic [NCH-1:0] dma_chan_req_o,
	input wire logic dma_wrap_ack_i,
	input wire logic [NCH-1:0] dma_chan_ack_i,
	// Interrupt
	output logic irq_o,
	// Event inputs
	input wire logic ev_zero_i,
	input wire logic ev_one_i,
	input wire logic [NCH-1:0] chan_ev_i,
	// Event outputs
	output logic ev_wrap_o,
	output logic ev_retrig_o,
	output logic ev_count_o,
	output logic [NCH-1:0] ev_match_o,
	// Actions
	output pwmtrq_pkg::pwmtrq_ctr_cmd_s ctr_cmd_o,
	output logic [NCH-1:0] chan_capture_o,
	output logic [NCH-1:0] chan_rec_fault_o
);
	import pwmtrq_pkg::*;

	// ==============================================================
	// Bus slave
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] main_q;
	logic [31:0] evc_q;
	logic [2*NCH-1:0] chact_q;
	logic [31:0] irq_en_q;
	logic [31:0] irq_flag_q;
	logic [CAP_W-1:0] cap_q [NCH];
	logic wrap_req_q;
	logic [NCH-1:0] chan_req_q;
	logic run_q;
	logic dir_q;

	wire req = wb_cyc_i && wb_stb_i;
	// A request is carried out at the edge where ack is sampled high
	wire acc = req && ack_q;
	wire wr = acc && wb_we_i && (wb_sel_i == 4'hF);
	wire rd = acc && !wb_we_i;
	wire wr_main = wr && (wb_adr_i == ADR_MAIN_CTRL);
	wire wr_cmd = wr && (wb_adr_i == ADR_CMD_SET);
	wire wr_chact = wr && (wb_adr_i == ADR_CHAN_ACT);
	wire wr_evc = wr && (wb_adr_i == ADR_EVENT_CTRL);
	wire wr_en_clr = wr && (wb_adr_i == ADR_IRQ_EN_CLR);
	wire wr_en_set = wr && (wb_adr_i == ADR_IRQ_EN_SET);
	wire wr_flag = wr && (wb_adr_i == ADR_IRQ_FLAG);
	wire oneshot_cmd = wr_cmd && (wb_dat_i[2:0] == CMD_ONESHOT_DMA);

	wire oneshot = main_q[MC_ONESHOT];
	wire [1:0] wave = main_q[MC_WAVE +: 2];
	wire [2:0] presc = main_q[MC_PRESC +: 3];
	wire [NCH-1:0] circ = main_q[MC_CIRC +: NCH];
	wire [NCH-1:0] capen = main_q[MC_CAPEN +: NCH];
	wire dual = (wave == WAVE_DUAL_RAMP) || (wave == WAVE_DUAL_RAMP_ALT);
	wire dual_slope_both_edges = (wave == WAVE_DUAL_SLOPE_BOTH);
	wire circ_on = (dual || dual_slope_both_edges) && (|circ);

	logic [31:0] rmux;
	logic [NCH-1:0] cap_read;
	always_comb begin
		rmux = 32'h0000_0000;
		cap_read = '0;
		unique case (wb_adr_i)
			ADR_MAIN_CTRL: rmux = main_q;
			ADR_CHAN_ACT: rmux = {{(32-2*NCH){1'b0}}, chact_q};
			ADR_EVENT_CTRL: rmux = evc_q;
			ADR_IRQ_EN_CLR, ADR_IRQ_EN_SET: rmux = irq_en_q;
			ADR_IRQ_FLAG: rmux = irq_flag_q;
			ADR_STATUS: rmux = {{(32-NCH-3){1'b0}}, chan_req_q, dir_q, run_q, wrap_req_q};
			default: rmux = 32'h0000_0000;
		endcase
		for (int i = 0; i < NCH; i++) begin
			if (wb_adr_i == ADR_CHAN_VAL0 + 8'(4 * i)) begin
				rmux = {{(32-CAP_W){1'b0}}, cap_q[i]};
				cap_read[i] = rd;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req && !ack_q;
			if (req && !ack_q) begin
				rdat_q <= rmux;
			end
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_q <= 32'h0000_0000;
			evc_q <= 32'h0000_0000;
			chact_q <= '0;
		end else begin
			if (wr_main) begin
				main_q <= wb_dat_i;
			end
			if (wr_evc) begin
				evc_q <= wb_dat_i;
			end
			if (wr_chact) begin
				chact_q <= wb_dat_i[2*NCH-1:0];
			end
		end
	end

	// ==============================================================
	// Interrupt flags and enables
	logic [31:0] irq_src;
	always_comb begin
		irq_src = 32'h0000_0000;
		irq_src[IF_WRAP] = cond_i.wrap; // R11
		irq_src[IF_RETRIG] = cond_i.retrig;
		irq_src[IF_COUNT] = cond_i.count;
		irq_src[IF_ERR] = cond_i.cap_err;
		irq_src[IF_DFS] = cond_i.dbg_fault;
		irq_src[IF_FAULT_A] = cond_i.rec_fault[0];
		irq_src[IF_FAULT_B] = cond_i.rec_fault[1];
		irq_src[IF_NONREC] = cond_i.nonrec_fault;
		irq_src[IF_MATCH +: NCH] = match_i | cap_valid_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_q <= 32'h0000_0000;
			irq_flag_q <= 32'h0000_0000;
		end else begin
			if (wr_en_set) begin
				irq_en_q <= irq_en_q | (wb_dat_i & IRQ_IMPL); // R12
			end else if (wr_en_clr) begin
				irq_en_q <= irq_en_q & ~wb_dat_i; // R12
			end
			// Set beats a simultaneous write-one clear
			irq_flag_q <= ((irq_flag_q & ~({32{wr_flag}} & wb_dat_i)) | irq_src) & IRQ_IMPL; // R23
		end
	end
	assign irq_o = |(irq_flag_q & irq_en_q); // R13 R14

	// ==============================================================
	// DMA requests
	logic os_pend_q;
	logic os_fire_q;
	logic in_b_q;
	logic b_ack_q;
	wire update = cond_i.wrap || cond_i.retrig;
	logic wrap_set;
	always_comb begin
		if (circ_on) begin
			wrap_set = cond_i.ramp_a_start && b_ack_q; // R8 R10
		end else if (oneshot) begin
			wrap_set = os_fire_q; // R2
		end else begin
			wrap_set = update; // R1
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			os_pend_q <= 1'b0;
			os_fire_q <= 1'b0;
			in_b_q <= 1'b0;
			b_ack_q <= 1'b0;
			wrap_req_q <= 1'b0;
		end else begin
			os_fire_q <= oneshot_cmd && (os_pend_q || update); // R2
			os_pend_q <= oneshot && !oneshot_cmd && (os_pend_q || update);
			if (cond_i.ramp_b_start) begin
				in_b_q <= 1'b1;
			end else if (cond_i.ramp_a_start) begin
				in_b_q <= 1'b0;
			end
			if (cond_i.ramp_a_start) begin
				b_ack_q <= 1'b0;
			// A circular channel transfer or a wrap ack in ramp B arms it; ramp A start clears it
			end else if (in_b_q && (dma_wrap_ack_i || |(dma_chan_ack_i & circ))) begin
				b_ack_q <= 1'b1;
			end
			wrap_req_q <= wrap_set || (wrap_req_q && !dma_wrap_ack_i); // R3
		end
	end
	assign dma_wrap_req_o = wrap_req_q;

	logic [NCH-1:0] chan_set;
	logic [NCH-1:0] chan_clr;
	for (genvar c = 0; c < NCH; c++) begin : g_chan
		wire [1:0] act = chact_q[2*c +: 2];
		wire ev_en = evc_q[EC_MCEI + c] && chan_ev_i[c]; // R21 R22
		always_comb begin
			if (capen[c]) begin
				chan_set[c] = cap_valid_i[c]; // R6
				chan_clr[c] = cap_read[c];
			end else if (circ[c] && (dual || dual_slope_both_edges)) begin
				chan_set[c] = cond_i.ramp_b_start; // R7 R9
				chan_clr[c] = dma_chan_ack_i[c];
			end else begin
				chan_set[c] = match_i[c] && !oneshot; // R4 R5
				chan_clr[c] = dma_chan_ack_i[c];
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				chan_req_q[c] <= 1'b0;
				cap_q[c] <= '0;
				chan_capture_o[c] <= 1'b0;
				chan_rec_fault_o[c] <= 1'b0;
				ev_match_o[c] <= 1'b0;
			end else begin
				chan_req_q[c] <= chan_set[c] || (chan_req_q[c] && !chan_clr[c]);
				if (cap_valid_i[c]) begin
					cap_q[c] <= cap_data_i[c*CAP_W +: CAP_W];
				end
				chan_capture_o[c] <= ev_en && (act == CH_CAPTURE); // R16
				chan_rec_fault_o[c] <= ev_en && (act == CH_REC_FAULT); // R16
				ev_match_o[c] <= evc_q[EC_MCEO + c] && (match_i[c] || cap_valid_i[c]); // R15
			end
		end
	end
	assign dma_chan_req_o = chan_req_q;

	// ==============================================================
	// Event outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_wrap_o <= 1'b0;
			ev_retrig_o <= 1'b0;
			ev_count_o <= 1'b0;
		end else begin
			ev_wrap_o <= cond_i.wrap && evc_q[EC_WRAP_EO]; // R15
			ev_retrig_o <= cond_i.retrig && evc_q[EC_RETRIG_EO];
			ev_count_o <= cond_i.count && evc_q[EC_COUNT_EO];
		end
	end

	// ==============================================================
	// Counter input events
	logic [6:0] div_q;
	logic ev0_q;
	logic presc_en;
	wire [7:0] div_full = 8'h01 << presc;
	assign presc_en = ({1'b0, div_q} == div_full - 8'h01);
	wire [2:0] a0_raw = evc_q[EC_ACT0 +: 3];
	wire [2:0] a1_raw = evc_q[EC_ACT1 +: 3];
	wire pwmtrq_ev0_e act0 = pwmtrq_ev0_e'(a0_raw);
	wire pwmtrq_ev1_e act1 = pwmtrq_ev1_e'(a1_raw);
	wire e0 = ev_zero_i && evc_q[EC_TCEI]; // R21
	wire e1 = ev_one_i && evc_q[EC_TCEI + 1]; // R21
	wire e0_rise = e0 && !ev0_q;
	logic [NCH-1:0] nonrec_mask;
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			nonrec_mask[i] = (chact_q[2*i +: 2] == CH_NONREC_FAULT);
		end
	end
	wire ch_nonrec = |(chan_ev_i & evc_q[EC_MCEI +: NCH] & nonrec_mask);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= 7'h00;
			ev0_q <= 1'b0;
			run_q <= 1'b0;
			dir_q <= 1'b0;
			ctr_cmd_o <= '0;
		end else begin
			div_q <= presc_en ? 7'h00 : div_q + 7'h01;
			ev0_q <= e0;
			// Once started, further events are ignored until the limit
			if (act0 == EV0_START && e0_rise && !run_q) begin
				run_q <= 1'b1; // R19
			end else if (cond_i.limit || act0 != EV0_START) begin
				run_q <= 1'b0; // R19
			end
			if (act1 == EV1_DIR && e1) begin
				dir_q <= ev_one_i; // R17
			end else if (act1 == EV1_DIR) begin
				dir_q <= 1'b0;
			end
			ctr_cmd_o.retrigger <= (act0 == EV0_RETRIG && e0) || (act1 == EV1_RETRIG && e1); // R18 R17
			ctr_cmd_o.step <= (act0 == EV0_COUNT && e0) // R18 R22
				|| (act0 == EV0_ACTIVE && e0 && presc_en) // R20
				|| (run_q && presc_en); // R19
			ctr_cmd_o.increment <= act0 == EV0_INC && e0; // R18
			ctr_cmd_o.decrement <= act1 == EV1_DEC && e1; // R17
			ctr_cmd_o.stop <= act1 == EV1_STOP && e1; // R17
			ctr_cmd_o.ppw_capture <= act1 == EV1_PPW && e1; // R17
			ctr_cmd_o.nonrec_fault <= (act0 == EV0_FAULT && e0) // R18
				|| (act1 == EV1_FAULT && e1) || ch_nonrec; // R17 R16
			ctr_cmd_o.dir_down <= dir_q;
			ctr_cmd_o.running <= run_q;
		end
	end

	// ==============================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_wrap_cont;
		!oneshot && !circ_on && update |=> dma_wrap_req_o;
	endproperty
	a_wrap_cont: assert property (p_wrap_cont) else $error("wrap request missing"); // R1

	sequence s_os_cmd;
		oneshot && !circ_on && update ##[1:8] oneshot && !circ_on && oneshot_cmd;
	endsequence
	property p_os_trig;
		s_os_cmd |=> ##1 dma_wrap_req_o;
	endproperty
	a_os_trig: assert property (p_os_trig) else $error("one-shot trigger missing"); // R2

	property p_os_quiet;
		oneshot && !circ_on && !os_fire_q && !dma_wrap_req_o |=> !dma_wrap_req_o;
	endproperty
	a_os_quiet: assert property (p_os_quiet) else $error("early one-shot trigger"); // R2

	property p_wrap_ack;
		dma_wrap_req_o && dma_wrap_ack_i && !wrap_set |=> !dma_wrap_req_o;
	endproperty
	a_wrap_ack: assert property (p_wrap_ack) else $error("wrap request not cleared"); // R3

	property p_ch_os;
		oneshot && !capen[0] && !(circ[0] && (dual || dual_slope_both_edges)) && !dma_chan_req_o[0]
			|=> !dma_chan_req_o[0];
	endproperty
	a_ch_os: assert property (p_ch_os) else $error("channel request in one-shot"); // R5

	property p_cap_read;
		capen[0] && cap_read[0] && !cap_valid_i[0] |=> !dma_chan_req_o[0];
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("capture request kept"); // R6

	property p_circ_b;
		(dual || dual_slope_both_edges) && circ[0] && !capen[0] && cond_i.ramp_b_start |=> dma_chan_req_o[0];
	endproperty
	a_circ_b: assert property (p_circ_b) else $error("circular request missing"); // R7 R9

	property p_circ_a;
		circ_on && cond_i.ramp_a_start && !b_ack_q && !dma_wrap_ack_i && !dma_wrap_req_o
			|=> !dma_wrap_req_o;
	endproperty
	a_circ_a: assert property (p_circ_a) else $error("wrap request without ack"); // R8 R10

	property p_irq;
		irq_o && !wr_flag && !wr_en_clr |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt line dropped"); // R13

	property p_flag_win;
		irq_src[IF_WRAP] |=> irq_flag_q[IF_WRAP];
	endproperty
	a_flag_win: assert property (p_flag_win) else $error("flag lost to clear"); // R23

	property p_eo_off;
		!evc_q[EC_WRAP_EO] && !wr_evc |=> !ev_wrap_o;
	endproperty
	a_eo_off: assert property (p_eo_off) else $error("event output not gated"); // R15
endmodule

// ### sim/pwm_timer_request_logic_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pwm_timer_request_logic_test;
	import pwmtrq_pkg::*;
	localparam pwmtrq_cond_s C_WRAP = 11'h400;
	localparam pwmtrq_cond_s C_RETRIG = 11'h200;
	localparam pwmtrq_cond_s C_RAMP_B = 11'h002;
	localparam pwmtrq_cond_s C_COUNT = 11'h100;
	localparam pwmtrq_cond_s C_RAMP_A = 11'h004;
	localparam pwmtrq_cond_s C_LIMIT = 11'h001;
	localparam logic [2:0] ACTS [10] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h5, 3'h1, 3'h3, 3'h4, 3'h6, 3'h5};
	localparam int BITS [10] = '{8, 7, 6, 0, 7, 8, 4, 5, 0, 1};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd;
	pwmtrq_cond_s cond = '0;
	logic [3:0] match = 4'h0;
	logic [3:0] capv = 4'h0;
	logic [3:0] chev = 4'h0;
	logic ev0 = 1'b0;
	logic ev1 = 1'b0;
	logic dma_en = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [63:0] capd = 64'h0000_A5C3_0000_0000;
	wire logic [31:0] wb_dat;
	wire logic ack;
	wire logic wrap_req;
	wire logic [3:0] chan_req;
	wire logic [4:0] dma_ack;
	wire logic irq;
	wire logic ev_wrap;
	wire logic ev_retrig;
	wire logic ev_count;
	wire logic [3:0] ev_match;
	wire pwmtrq_ctr_cmd_s cmd;
	wire logic [3:0] capt;
	wire logic [3:0] recf;
	wire logic [4:0] reqs = {chan_req, wrap_req};
	int mismatches = 0;
	int n_tests = 0;
	always #5 clk_i = ~clk_i;
	pwmtrq_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
		.cond_i(cond), .match_i(match), .cap_valid_i(capv), .cap_data_i(capd),
		.dma_wrap_req_o(wrap_req), .dma_chan_req_o(chan_req), .dma_wrap_ack_i(dma_ack[0]),
		.dma_chan_ack_i(dma_ack[4:1]), .irq_o(irq), .ev_zero_i(ev0), .ev_one_i(ev1),
		.chan_ev_i(chev), .ev_wrap_o(ev_wrap), .ev_retrig_o(ev_retrig), .ev_count_o(ev_count),
		.ev_match_o(ev_match), .ctr_cmd_o(cmd), .chan_capture_o(capt), .chan_rec_fault_o(recf));
	pwmtrq_dma_model dma (.clk_i(clk_i), .rst_i(rst_i), .en_i(dma_en), .dly_i(dly),
		.req_i(reqs), .ack_o(dma_ack));
	// ==============================================================
	// Shared tasks
	task automatic tally_and_finish();
		$display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic fail_out();
		mismatches++;
		tally_and_finish();
	endtask
	// Holds the request until ack is sampled high, then releases
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
		end
		rd = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i == 20) fail_out();
	endtask
	// One-cycle stimulus; returns in the cycle its registered effects stand
	task automatic pulse(input pwmtrq_cond_s c, input logic [3:0] m, input logic [3:0] v,
		input logic [1:0] e, input logic [3:0] ce);
		@(posedge clk_i);
		cond <= c;
		match <= m;
		capv <= v;
		ev0 <= e[0];
		ev1 <= e[1];
		chev <= ce;
		@(posedge clk_i);
		cond <= '0;
		match <= 4'h0;
		capv <= 4'h0;
		ev0 <= 1'b0;
		ev1 <= 1'b0;
		chev <= 4'h0;
		#1;
	endtask
	task automatic setdma(input logic en, input logic [3:0] d);
		@(posedge clk_i);
		dma_en <= en;
		dly <= d;
	endtask
	task automatic wait_clear(input int k);
		int i;
		for (i = 0; i < 30; i++) begin
			@(posedge clk_i);
			#1;
			if (reqs[k] === 1'b0) break;
		end
		`CHK(reqs[k], 1'b0)
		if (i == 30) fail_out();
	endtask
	// ==============================================================
	// Scenarios
	task automatic t_wrap_dma();
		wb(1'b1, ADR_EVENT_CTRL, 32'h700);
		for (int i = 0; i < 2; i++) begin
			setdma(1'b0, 4'h6);
			pulse(i ? C_RETRIG : C_WRAP, 4'h0, 4'h0, 2'b00, 4'h0);
			`CHK(wrap_req, 1'b1)
			`CHK({ev_wrap, ev_retrig}, i ? 2'b01 : 2'b10)
			repeat (3) @(posedge clk_i);
			#1;
			`CHK(wrap_req, 1'b1)
			setdma(1'b1, 4'h6);
			wait_clear(0);
		end
		pulse(C_COUNT, 4'h0, 4'h0, 2'b00, 4'h0);
		`CHK(ev_count, 1'b1)
		$display("wrap dma done");
	endtask
	task automatic t_oneshot();
		setdma(1'b0, 4'h0);
		wb(1'b1, ADR_MAIN_CTRL, 32'h1);
		pulse(C_WRAP, 4'h0, 4'h0, 2'b00, 4'h0);
		`CHK(wrap_req, 1'b0)
		pulse('0, 4'h1, 4'h0, 2'b00, 4'h0);
		`CHK(chan_req, 4'h0)
		wb(1'b1, ADR_CMD_SET, {29'h0, CMD_ONESHOT_DMA});
		@(posedge clk_i);
		#1;
		`CHK(wrap_req, 1'b1)
		setdma(1'b1, 4'h0);
		wait_clear(0);
		$display("oneshot done");
	endtask
	task automatic t_irq();
		wb(1'b1, ADR_IRQ_EN_SET, 32'h1);
		wb(1'b1, ADR_IRQ_EN_SET, 32'h0);
		wb(1'b0, ADR_IRQ_EN_CLR, 32'h0);
		`CHK(rd, 32'h1)
		pulse(C_WRAP, 4'h0, 4'h0, 2'b00, 4'h0);
		wb(1'b0, ADR_IRQ_FLAG, 32'h0);
		`CHK(rd[IF_WRAP], 1'b1)
		`CHK(irq, 1'b1)
		wb(1'b1, ADR_IRQ_FLAG, 32'h0);
		wb(1'b1, ADR_IRQ_EN_CLR, 32'h1);
		#1;
		`CHK(irq, 1'b0)
		wb(1'b1, ADR_IRQ_EN_SET, 32'h1);
		#1;
		`CHK(irq, 1'b1)
		wb(1'b1, ADR_IRQ_FLAG, 32'h1);
		#1;
		`CHK(irq, 1'b0)
		// Clear and a new wrap condition at the same edge: the condition wins
		fork
			wb(1'b1, ADR_IRQ_FLAG, 32'h1);
			begin
				repeat (2) @(posedge clk_i);
				cond <= C_WRAP;
				@(posedge clk_i);
				cond <= '0;
			end
		join
		#1;
		`CHK(irq, 1'b1)
		wb(1'b0, 8'hFC, 32'h0);
		`CHK(rd, 32'h0)
		$display("irq done");
	endtask
	task automatic t_chan();
		setdma(1'b1, 4'h0);
		wb(1'b1, ADR_MAIN_CTRL, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wb(1'b1, ADR_EVENT_CTRL, i ? 32'h0 : 32'h1 << EC_MCEO);
			pulse('0, 4'h1, 4'h0, 2'b00, 4'h0);
			`CHK(chan_req[0], 1'b1)
			`CHK(ev_match, i ? 4'h0 : 4'h1)
			wait_clear(1);
		end
		$display("compare channel done");
	endtask
	task automatic t_cap();
		setdma(1'b0, 4'h0);
		wb(1'b1, ADR_MAIN_CTRL, 32'h1 | 32'h1 << (MC_CAPEN + 2));
		pulse('0, 4'h0, 4'h4, 2'b00, 4'h0);
		`CHK(chan_req[2], 1'b1)
		wb(1'b0, ADR_CHAN_VAL0 + 8'h08, 32'h0);
		`CHK(rd[15:0], 16'hA5C3)
		wait_clear(3);
		$display("capture done");
	endtask
	task automatic t_circ();
		setdma(1'b1, 4'h0);
		for (int w = 1; w < 4; w++) begin
			wb(1'b1, ADR_MAIN_CTRL, 32'h100 | 32'(w) << MC_WAVE);
			pulse('0, 4'h1, 4'h0, 2'b00, 4'h0);
			`CHK(chan_req[0], 1'b0)
			pulse(C_RAMP_B, 4'h0, 4'h0, 2'b00, 4'h0);
			`CHK(chan_req[0], 1'b1)
			wait_clear(1);
			pulse(C_RAMP_A, 4'h0, 4'h0, 2'b00, 4'h0);
			`CHK(wrap_req, 1'b1)
			wait_clear(0);
			pulse(C_RAMP_A, 4'h0, 4'h0, 2'b00, 4'h0);
			`CHK(wrap_req, 1'b0)
		end
		$display("circular done");
	endtask
	task automatic t_events();
		for (int k = 0; k < 10; k++) begin
			wb(1'b1, ADR_EVENT_CTRL, k < 5 ? 32'(ACTS[k]) | 32'h1 << EC_TCEI
				: 32'(ACTS[k]) << EC_ACT1 | 32'h1 << (EC_TCEI + 1));
			pulse('0, 4'h0, 4'h0, k < 5 ? 2'b01 : 2'b10, 4'h0);
			`CHK(cmd & 9'h1F3, 9'h1 << BITS[k])
		end
		wb(1'b1, ADR_EVENT_CTRL, 32'(EV1_DIR) << EC_ACT1 | 32'h1 << (EC_TCEI + 1));
		pulse('0, 4'h0, 4'h0, 2'b10, 4'h0);
		@(posedge clk_i);
		#1;
		`CHK(cmd.dir_down, 1'b1)
		wb(1'b1, ADR_EVENT_CTRL, 32'(EV0_START) | 32'h1 << EC_TCEI);
		pulse('0, 4'h0, 4'h0, 2'b01, 4'h0);
		@(posedge clk_i);
		#1;
		`CHK({cmd.running, cmd.step}, 2'b11)
		pulse(C_LIMIT, 4'h0, 4'h0, 2'b00, 4'h0);
		@(posedge clk_i);
		#1;
		`CHK(cmd.running, 1'b0)
		wb(1'b1, ADR_EVENT_CTRL, 32'h1);
		pulse('0, 4'h0, 4'h0, 2'b01, 4'h0);
		`CHK(cmd.retrigger, 1'b0)
		wb(1'b1, ADR_EVENT_CTRL, 32'h1 | 32'h1 << EC_TCEI);
		for (int i = 0; i < 2; i++) begin
			pulse('0, 4'h0, 4'h0, 2'b01, 4'h0);
			`CHK(cmd.retrigger, 1'b1)
		end
		wb(1'b1, ADR_CHAN_ACT, {26'h0, CH_NONREC_FAULT, CH_REC_FAULT, CH_CAPTURE});
		wb(1'b1, ADR_EVENT_CTRL, 32'h7 << EC_MCEI);
		pulse('0, 4'h0, 4'h0, 2'b00, 4'h7);
		`CHK({capt, recf, cmd.nonrec_fault}, 9'h025)
		$display("events done");
	endtask
	// ==============================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK({irq, reqs}, 6'h00)
		t_wrap_dma();
		t_oneshot();
		t_irq();
		t_chan();
		t_cap();
		t_circ();
		t_events();
		tally_and_finish();
	end
endmodule

// ### sim/pwmtrq_dma_model.sv
`timescale 1ns/1ps
// ==============================================================
// DMA controller side: acknowledges each standing request dly_i + 1 cycles after it rises
module pwmtrq_dma_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Behaviour control
	input wire logic en_i,
	input wire logic [3:0] dly_i,
	// Requests and acknowledges, bit 0 wrap, bits 4:1 channels
	input wire logic [4:0] req_i,
	output logic [4:0] ack_o
);
	logic [3:0] cnt_q [5];
	// Low en_i stalls the controller so a request must stand on its own
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 5; i++) begin
			ack_o[i] <= 1'b0;
			if (rst_i || !req_i[i] || ack_o[i] || !en_i) begin
				cnt_q[i] <= 4'h0;
			end else if (cnt_q[i] >= dly_i) begin
				ack_o[i] <= 1'b1;
			end else begin
				cnt_q[i] <= cnt_q[i] + 4'h1;
			end
		end
	end
endmodule
